// ---- rtl/nab_core.sv ----
// Program banks, address registers, control unit and node memory
//
// Notes on behaviour
// - Bank A address: mpu or control unit
// - Program address steps after each instruction
// - Result address idle except during collect
// - Result address steps per four bytes
// - Host address steps on latch once enabled
// - Address registers readable and writable by mpu
// - Selected 2:1 muxes route addresses
// - Bank B write strobe low when writing
// - Bank data to instruction reg or host
// - Two banks of 64k 32-bit words
// - Create sends forward then reverse relation
// - Lookup or assign ids, else collect garbage
// - Reallocate on full chip, bump counts
// - Delete sends both, lowers counts
// - Collect stores responding ids in table
// - Other primitives pass through unchanged
// - Opcode map gives microprogram entry
// - Status flags and begin in one register
// - Chip counts addressed by id chip bits
// - Name to id and id to name memories
// - Idle scan pushes free ids on stack
// - Id zero means unassigned, never allocated
// - New name pops id from free stack
// - Latch pulse is ownership with strobe
`timescale 1ns/10ps
module nab_core
  import nab_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        onboard_request_i,
  input  wire logic        local_bus_owned_i,
  input  wire logic        data_strobe_any_n_i,
  input  wire logic        host_rw_n_i,
  input  wire logic [31:0] host_wdata_i,
  output logic      [31:0] host_rdata_o,
  output logic             bank_b_write_strobe_n_o,
  output logic      [47:0] array_instr_o,
  output logic             array_instr_valid_o,
  input  wire logic [7:0]  array_byte_i,
  input  wire logic        array_byte_valid_i,
  input  wire logic        array_collect_done_i
);
  localparam int SYNC_W = 46;

  // Program banks and node memories
  logic [31:0]             bank_mem   [2][`NAB_BANK_WORDS];
  logic [`NAB_ID_W-1:0]    name_to_id [`NAB_NAMES];
  logic [`NAB_NAME_W-1:0]  id_to_name [`NAB_IDS];
  logic [`NAB_CNT_W-1:0]   rel_cnt    [`NAB_IDS];
  logic [`NAB_CNT_W-1:0]   chip_cnt   [`NAB_CHIPS];
  logic [1:0]              id_state   [`NAB_IDS];
  logic [`NAB_ID_W-1:0]    var_tab    [`NAB_NAMES];
  logic [`NAB_ID_W-1:0]    lifo       [`NAB_LIFO_DEPTH];

  logic [SYNC_W-1:0]       sync1_reg, sync2_reg;
  logic                    onboard_request_s, owned_s, ds_n_s, rw_n_s, dr_s, cdone_s;
  logic [7:0]              byte_s;
  logic [31:0]             hdata_s;
  logic                    ds_prev_reg, dr_prev_reg;
  logic                    latch_pulse, dr_pulse;
  logic                    pready_reg, pslverr_reg;
  logic [31:0]             prdata_reg, rd_next;
  logic                    rd_hit, apb_wr;
  logic                    begin_reg, sel_req_reg, sel_act_reg, host_en_reg;
  logic [3:0]              flags_reg, ev_reg, flag_clr;
  logic [`NAB_ADDR_W-1:0]  prog_addr_reg, result_addr_reg, host_addr_reg;
  logic [`NAB_ADDR_W-1:0]  cu_addr;
  logic [`NAB_ADDR_W-1:0]  bank_addr  [2];
  logic [31:0]             bank_q     [2];
  logic                    cu_bank, host_bank;
  logic [31:0]             host_rdata_reg;
  logic                    we_b_n_reg;
  nab_cu_state_t           state_reg;
  logic [31:0]             ir_reg;
  logic                    nk_reg;
  logic [`NAB_ID_W-1:0]    id_a_reg, id_b_reg, cur_id_reg, clr_reg, scan_reg;
  logic [`NAB_ID_W-1:0]    looked, lifo_top;
  logic [1:0]              byte_cnt_reg;
  logic [23:0]             pack_reg;
  logic [`NAB_NAME_W-1:0]  var_cnt_reg, cur_name;
  logic [`NAB_SP_W-1:0]    sp_reg;
  logic [47:0]             ainstr_reg;
  logic                    avalid_reg;
  logic                    col_wr, is_del, scan_run, lifo_empty;
  logic [31:0]             col_word;
  logic [7:0]              op;

  // Two flip-flop synchronisers for every host and array pin input
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {onboard_request_i, local_bus_owned_i, data_strobe_any_n_i,
                    host_rw_n_i, array_byte_valid_i, array_collect_done_i,
                    array_byte_i, host_wdata_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign {onboard_request_s, owned_s, ds_n_s, rw_n_s, dr_s, cdone_s, byte_s, hdata_s} = sync2_reg;

  // Edge detectors on the synchronised strobes
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ds_prev_reg <= 1'b0;
      dr_prev_reg <= 1'b0;
    end else begin
      ds_prev_reg <= ds_n_s;
      dr_prev_reg <= dr_s;
    end
  end

  assign latch_pulse = owned_s & ds_prev_reg & ~ds_n_s;
  assign dr_pulse    = dr_s & ~dr_prev_reg;

  // Bus slave: one wait state, then pready with data
  assign apb_wr = psel_i & penable_i & pready_reg & pwrite_i;
  assign flag_clr = (apb_wr && paddr_i == `NAB_OFF_CSR) ?
                    pwdata_i[`NAB_CSR_FLAG_MSB:`NAB_CSR_FLAG_LSB] : 4'h0;
  assign lifo_empty = (sp_reg == '0);

  // Read decode, unmapped offsets answer with an error
  always_comb begin
    rd_hit  = 1'b1;
    rd_next = 32'h0000_0000;
    unique case (paddr_i)
      `NAB_OFF_CSR:   rd_next = {16'h0000, lifo_empty, state_reg != CU_IDLE,
                                 sel_act_reg, onboard_request_s, flags_reg, 4'h0,
                                 host_en_reg, 1'b0, sel_req_reg, begin_reg};
      `NAB_OFF_PADDR: rd_next = {16'h0000, prog_addr_reg};
      `NAB_OFF_RADDR: rd_next = {16'h0000, result_addr_reg};
      `NAB_OFF_HADDR: rd_next = {16'h0000, host_addr_reg};
      default:        rd_hit  = 1'b0;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel_i & penable_i & ~pready_reg;
      pslverr_reg <= psel_i & penable_i & ~pready_reg & ~rd_hit;
      prdata_reg  <= (psel_i & ~pwrite_i) ? rd_next : 32'h0000_0000;
    end
  end

  // Control status register: begin, bank select, sticky flags
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      begin_reg   <= 1'b0;
      sel_req_reg <= 1'b0;
      sel_act_reg <= 1'b0;
      host_en_reg <= 1'b0;
      flags_reg   <= 4'h0;
    end else begin
      if (apb_wr && paddr_i == `NAB_OFF_CSR) begin
        begin_reg   <= pwdata_i[`NAB_CSR_BEGIN];
        sel_req_reg <= pwdata_i[`NAB_CSR_SEL];
        host_en_reg <= pwdata_i[`NAB_CSR_HOST_EN];
      end
      if (ev_reg[`NAB_FLAG_DONE]) begin
        begin_reg <= 1'b0;
      end
      flags_reg <= (flags_reg & ~flag_clr) | ev_reg;
      if (state_reg == CU_IDLE && !owned_s) begin
        sel_act_reg <= sel_req_reg;
      end
    end
  end

  // Program address: counter stepped after each instruction
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prog_addr_reg <= '0;
    end else if (apb_wr && paddr_i == `NAB_OFF_PADDR) begin
      prog_addr_reg <= pwdata_i[`NAB_ADDR_W-1:0];
    end else if (state_reg == CU_NEXT) begin
      prog_addr_reg <= prog_addr_reg + 1'b1;
    end
  end

  // Result address: only moves while a collect runs
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      result_addr_reg <= '0;
    end else if (apb_wr && paddr_i == `NAB_OFF_RADDR) begin
      result_addr_reg <= pwdata_i[`NAB_ADDR_W-1:0];
    end else if (col_wr) begin
      result_addr_reg <= result_addr_reg + 1'b1;
    end
  end

  // Host address: stepped by each latch pulse once enabled
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      host_addr_reg <= '0;
    end else if (apb_wr && paddr_i == `NAB_OFF_HADDR) begin
      host_addr_reg <= pwdata_i[`NAB_ADDR_W-1:0];
    end else if (latch_pulse && host_en_reg) begin
      host_addr_reg <= host_addr_reg + 1'b1;
    end
  end

  // Bank steering: select 0 gives bank A to the control unit
  assign cu_bank   = sel_act_reg;
  assign host_bank = ~sel_act_reg;
  assign cu_addr   = (state_reg == CU_COLLECT) ? result_addr_reg : prog_addr_reg;

  // Address 2:1 mux and data read per bank
  for (genvar b = 0; b < 2; b++) begin : g_bank
    assign bank_addr[b] = (cu_bank == 1'(b)) ? cu_addr : host_addr_reg;
    assign bank_q[b]    = bank_mem[b][bank_addr[b]];
  end

  // Bank writes: collect words on the unit side, host words on the other
  always_ff @(posedge clock_i) begin
    if (col_wr) begin
      bank_mem[cu_bank][bank_addr[cu_bank]] <= col_word;
    end
    if (latch_pulse && !rw_n_s) begin
      bank_mem[host_bank][bank_addr[host_bank]] <= hdata_s;
    end
  end

  // Host read data and bank B write strobe
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      host_rdata_reg <= 32'h0000_0000;
      we_b_n_reg     <= 1'b1;
    end else begin
      if (latch_pulse && rw_n_s) begin
        host_rdata_reg <= bank_q[host_bank];
      end
      we_b_n_reg <= ~(~rw_n_s & owned_s & host_bank);
    end
  end

  // Control unit helpers
  assign op       = ir_reg[31:24];
  assign is_del   = (op == `NAB_OP_DELETE);
  assign cur_name = nk_reg ? ir_reg[7:0] : ir_reg[23:16];
  assign looked   = name_to_id[cur_name];
  assign lifo_top = lifo[sp_reg[3:0] - 4'h1];
  assign col_word = {pack_reg, byte_s};
  assign col_wr   = (state_reg == CU_COLLECT) && dr_pulse && (byte_cnt_reg == 2'h3);
  assign scan_run = (state_reg == CU_IDLE) || (state_reg == CU_ALLOC && lifo_empty);

  // Control unit sequencer with node memory bookkeeping
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg    <= CU_CLEAR;
      ir_reg       <= 32'h0000_0000;
      nk_reg       <= 1'b0;
      id_a_reg     <= '0;
      id_b_reg     <= '0;
      cur_id_reg   <= '0;
      clr_reg      <= '0;
      scan_reg     <= '0;
      sp_reg       <= '0;
      byte_cnt_reg <= 2'h0;
      pack_reg     <= 24'h00_0000;
      var_cnt_reg  <= '0;
      ev_reg       <= 4'h0;
      ainstr_reg   <= 48'h0000_0000_0000;
      avalid_reg   <= 1'b0;
    end else begin
      ev_reg     <= 4'h0;
      avalid_reg <= 1'b0;
      unique case (state_reg)
        CU_CLEAR: begin
          name_to_id[clr_reg[7:0]] <= '0;
          chip_cnt[clr_reg[7:0]]   <= '0;
          rel_cnt[clr_reg]         <= '0;
          id_state[clr_reg]        <= `NAB_ID_FREE;
          clr_reg <= clr_reg + 1'b1;
          if (&clr_reg) begin
            state_reg <= CU_IDLE;
          end
        end
        CU_IDLE: begin
          if (begin_reg) begin
            state_reg <= CU_FETCH;
          end
        end
        CU_FETCH: begin
          ir_reg    <= bank_q[cu_bank];
          state_reg <= CU_DECODE;
        end
        CU_DECODE: begin
          nk_reg       <= 1'b0;
          byte_cnt_reg <= 2'h0;
          var_cnt_reg  <= '0;
          state_reg    <= nab_entry(op);
          if (op == `NAB_OP_HALT) begin
            ev_reg[`NAB_FLAG_DONE] <= 1'b1;
          end
          if (nab_entry(op) == CU_COLLECT) begin
            ainstr_reg <= {16'h0000, ir_reg};
            avalid_reg <= 1'b1;
          end
        end
        CU_PASS: begin
          ainstr_reg <= {16'h0000, ir_reg};
          avalid_reg <= 1'b1;
          state_reg  <= CU_NEXT;
        end
        CU_LOOK: begin
          if (looked == '0) begin
            if (is_del) begin
              ev_reg[`NAB_FLAG_DELERR] <= 1'b1;
              state_reg <= CU_NEXT;
            end else begin
              state_reg <= CU_ALLOC;
            end
          end else if (is_del) begin
            if (nk_reg) begin
              id_b_reg  <= looked;
              state_reg <= CU_FWD;
            end else begin
              id_a_reg <= looked;
              nk_reg   <= 1'b1;
            end
          end else begin
            cur_id_reg <= looked;
            state_reg  <= CU_CHIP;
          end
        end
        CU_ALLOC: begin
          if (lifo_empty) begin
            ev_reg[`NAB_FLAG_GC] <= 1'b1;
          end else begin
            cur_id_reg             <= lifo_top;
            sp_reg                 <= sp_reg - 1'b1;
            name_to_id[cur_name]   <= lifo_top;
            id_to_name[lifo_top]   <= cur_name;
            id_state[lifo_top]     <= `NAB_ID_BOUND;
            state_reg              <= CU_CHIP;
          end
        end
        CU_CHIP: begin
          if (chip_cnt[cur_id_reg[`NAB_ID_W-1:`NAB_CHIP_LSB]] == `NAB_CHIP_LIMIT) begin
            ev_reg[`NAB_FLAG_OVF] <= 1'b1;
            id_state[cur_id_reg]  <= `NAB_ID_FREE;
            state_reg             <= CU_ALLOC;
          end else begin
            rel_cnt[cur_id_reg] <= rel_cnt[cur_id_reg] + 1'b1;
            chip_cnt[cur_id_reg[`NAB_ID_W-1:`NAB_CHIP_LSB]] <=
              chip_cnt[cur_id_reg[`NAB_ID_W-1:`NAB_CHIP_LSB]] + 1'b1;
            if (nk_reg) begin
              id_b_reg  <= cur_id_reg;
              state_reg <= CU_FWD;
            end else begin
              id_a_reg  <= cur_id_reg;
              nk_reg    <= 1'b1;
              state_reg <= CU_LOOK;
            end
          end
        end
        CU_FWD: begin
          ainstr_reg <= {op, ir_reg[15:8], 2'b00, id_a_reg, 2'b00, id_b_reg};
          avalid_reg <= 1'b1;
          if (is_del) begin
            rel_cnt[id_a_reg] <= rel_cnt[id_a_reg] - 1'b1;
            chip_cnt[id_a_reg[`NAB_ID_W-1:`NAB_CHIP_LSB]] <=
              chip_cnt[id_a_reg[`NAB_ID_W-1:`NAB_CHIP_LSB]] - 1'b1;
          end
          state_reg <= CU_REV;
        end
        CU_REV: begin
          ainstr_reg <= {op, ir_reg[15:8] | 8'h80, 2'b00, id_b_reg, 2'b00, id_a_reg};
          avalid_reg <= 1'b1;
          if (is_del) begin
            rel_cnt[id_b_reg] <= rel_cnt[id_b_reg] - 1'b1;
            chip_cnt[id_b_reg[`NAB_ID_W-1:`NAB_CHIP_LSB]] <=
              chip_cnt[id_b_reg[`NAB_ID_W-1:`NAB_CHIP_LSB]] - 1'b1;
          end
          state_reg <= CU_NEXT;
        end
        CU_COLLECT: begin
          if (dr_pulse) begin
            pack_reg     <= {pack_reg[15:0], byte_s};
            byte_cnt_reg <= byte_cnt_reg + 1'b1;
            if (byte_cnt_reg == 2'h3 && op != `NAB_OP_READ) begin
              var_tab[ir_reg[7:0] + var_cnt_reg] <= col_word[`NAB_ID_W-1:0];
              var_cnt_reg <= var_cnt_reg + 1'b1;
            end
          end
          if (cdone_s) begin
            state_reg <= CU_NEXT;
          end
        end
        CU_NEXT: begin
          state_reg <= CU_IDLE;
        end
      endcase
      // Free id scan while idle or while allocation waits on an empty stack
      if (scan_run) begin
        scan_reg <= scan_reg + 1'b1;
        if (scan_reg != '0 && id_state[scan_reg] == `NAB_ID_FREE &&
            sp_reg != `NAB_SP_W'(`NAB_LIFO_DEPTH)) begin
          lifo[sp_reg[3:0]]  <= scan_reg;
          sp_reg             <= sp_reg + 1'b1;
          id_state[scan_reg] <= `NAB_ID_QUEUED;
        end
      end
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o                = prdata_reg;
  assign pready_o                = pready_reg;
  assign pslverr_o               = pslverr_reg;
  assign host_rdata_o            = host_rdata_reg;
  assign bank_b_write_strobe_n_o = we_b_n_reg;
  assign array_instr_o           = ainstr_reg;
  assign array_instr_valid_o     = avalid_reg;

  // Checks on the sequencer and address registers
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_fwd_sent;
    array_instr_valid_o && array_instr_o[47:32] == {op, ir_reg[15:8]};
  endsequence
  sequence s_rev_sent;
    array_instr_valid_o && array_instr_o[39:32] == (ir_reg[15:8] | 8'h80);
  endsequence

  AST_PROG_STEP: assert property (
    state_reg == CU_NEXT && !apb_wr |=> prog_addr_reg == $past(prog_addr_reg) + 16'h0001)
    else $error("program address did not step");
  AST_RESULT_HOLD: assert property (
    state_reg != CU_COLLECT && !apb_wr |=> $stable(result_addr_reg))
    else $error("result address moved outside collect");
  AST_RESULT_STEP: assert property (
    col_wr && !apb_wr |=> result_addr_reg == $past(result_addr_reg) + 16'h0001)
    else $error("result address missed a word");
  AST_HOST_STEP: assert property (
    latch_pulse && host_en_reg && !apb_wr |=> host_addr_reg == $past(host_addr_reg) + 16'h0001)
    else $error("host address missed a latch");
  AST_WE_B: assert property (
    !rw_n_s && owned_s && host_bank |=> !bank_b_write_strobe_n_o)
    else $error("bank B write strobe not low");
  AST_FWD_REV: assert property (
    state_reg == CU_FWD |=> s_fwd_sent ##1 s_rev_sent)
    else $error("forward then reverse not sent");
  AST_SEL_SAFE: assert property (
    $changed(sel_act_reg) |-> $past(state_reg == CU_IDLE && !owned_s))
    else $error("bank switched during an access");
  AST_NO_ID0: assert property (
    state_reg == CU_CHIP |-> cur_id_reg != '0)
    else $error("node id zero allocated");
  AST_PASS: assert property (
    state_reg == CU_PASS |=> array_instr_valid_o && array_instr_o[31:0] == $past(ir_reg))
    else $error("primitive not passed unchanged");
  AST_DONE_FLAG: assert property (
    state_reg == CU_DECODE && op == `NAB_OP_HALT |=> ##1 flags_reg[`NAB_FLAG_DONE] && !begin_reg)
    else $error("execution complete not reported");
endmodule

// ---- rtl/nab_defs.svh ----
// Constants for the node allocation and memory bank block
`ifndef NAB_DEFS_SVH
`define NAB_DEFS_SVH
// Register byte offsets
`define NAB_OFF_CSR      8'h00
`define NAB_OFF_PADDR    8'h04
`define NAB_OFF_RADDR    8'h08
`define NAB_OFF_HADDR    8'h0C
// Control status register fields
`define NAB_CSR_BEGIN    0
`define NAB_CSR_SEL      1
`define NAB_CSR_HOST_EN  3
`define NAB_CSR_FLAG_LSB 8
`define NAB_CSR_FLAG_MSB 11
// Flag index inside the four flag bits
`define NAB_FLAG_OVF     0
`define NAB_FLAG_DELERR  1
`define NAB_FLAG_DONE    2
`define NAB_FLAG_GC      3
// Widths and sizes
`define NAB_ADDR_W       16
`define NAB_BANK_WORDS   65536
`define NAB_ID_W         14
`define NAB_IDS          16384
`define NAB_NAME_W       8
`define NAB_NAMES        256
`define NAB_CNT_W        8
`define NAB_CHIP_LSB     6
`define NAB_CHIPS        256
`define NAB_LIFO_DEPTH   16
`define NAB_SP_W         5
`define NAB_CHIP_LIMIT   8'hFF
`define NAB_REV_BIT      7
// Node id states
`define NAB_ID_FREE      2'h0
`define NAB_ID_QUEUED    2'h1
`define NAB_ID_BOUND     2'h2
// Primitive opcodes
`define NAB_OP_HALT      8'h00
`define NAB_OP_CREATE    8'h01
`define NAB_OP_DELETE    8'h02
`define NAB_OP_COLLECT   8'h03
`define NAB_OP_COLL_COL  8'h04
`define NAB_OP_COLL_REL  8'h05
`define NAB_OP_READ      8'h06
`endif

// ---- rtl/nab_pkg.sv ----
// Types and opcode map for the node allocation and memory bank block
`include "nab_defs.svh"
package nab_pkg;
  typedef enum logic [3:0] {
    CU_CLEAR, CU_IDLE, CU_FETCH, CU_DECODE, CU_PASS, CU_LOOK,
    CU_ALLOC, CU_CHIP, CU_FWD, CU_REV, CU_COLLECT, CU_NEXT
  } nab_cu_state_t;

  // Opcode map: opcode to first control step of its sequence
  function automatic nab_cu_state_t nab_entry(input logic [7:0] op);
    unique case (op)
      `NAB_OP_HALT:     nab_entry = CU_NEXT;
      `NAB_OP_CREATE,
      `NAB_OP_DELETE:   nab_entry = CU_LOOK;
      `NAB_OP_COLLECT,
      `NAB_OP_COLL_COL,
      `NAB_OP_COLL_REL,
      `NAB_OP_READ:     nab_entry = CU_COLLECT;
      default:          nab_entry = CU_PASS;
    endcase
  endfunction
endpackage

// ---- sim/nab_core_bench.sv ----
// Self-checking bench for the node allocation and memory bank core
`timescale 1ns/10ps
module nab_core_bench;
  logic clock_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, hrd, r, v, ins0, cw, exw;
  logic [47:0] ains, w;
  logic [15:0] ra;
  logic [7:0]  nm, rl, ab = 8'h00;
  logic        adv = 1'b0, adone = 1'b0;
  int          fq[$];
  int          ia, ib;
  logic pready, perr, wsn, aval, e, own, sn, rwn, seen_low = 1'b0;
  logic [31:0] hwd;
  int bad_count = 0, tests_run = 0, cyc = 0;

  always #50 clock_i = ~clock_i;

  nab_host_model nab_host_model_inst (.clock_i(clock_i), .owned_o(own), .strobe_n_o(sn),
    .rw_n_o(rwn), .wdata_o(hwd));

  nab_core nab_core_inst (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .onboard_request_i(own),
    .local_bus_owned_i(own), .data_strobe_any_n_i(sn), .host_rw_n_i(rwn),
    .host_wdata_i(hwd), .host_rdata_o(hrd), .bank_b_write_strobe_n_o(wsn),
    .array_instr_o(ains), .array_instr_valid_o(aval), .array_byte_i(ab),
    .array_byte_valid_i(adv), .array_collect_done_i(adone));

  // Cycle ceiling and write strobe watch
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (wsn === 1'b0) seen_low <= 1'b1;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      bad_count = bad_count + 1;
    end
  endtask

  // Wide compare in two parts, upper 32 bits then lower 16 bits
  task automatic chk48(input logic [47:0] got, input logic [47:0] exp);
    chk(got[47:16], exp[47:16]);
    chk({16'h0000, got[15:0]}, {16'h0000, exp[15:0]});
  endtask

  // Wait for the next array instruction pulse and take its word
  task automatic next_instr(output logic [47:0] got);
    do @(posedge clock_i); while (aval !== 1'b1);
    got = ains;
  endtask

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input int wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1; pwrite <= 1'(wr); paddr <= a; pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence with an integer model of registers and program words
  initial begin
    void'($urandom(32'hc7bbcbd8));
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    chk(32'({pready, perr, wsn, aval}), 32'h2); chk48(ains, 48'h0);
    do apb(0, 8'h00, 0); while (r[14] !== 1'b0);
    // Address registers read back what was written
    for (int i = 1; i < 4; i++) begin
      v = $urandom & 32'hFFFF;
      apb(1, 8'(i * 4), v); apb(0, 8'(i * 4), 0); chk(r, v);
    end
    apb(1, 8'h10, 32'h5); chk(32'(e), 32'h1); apb(0, 8'h10, 0); chk({e, r[30:0]}, 32'h80000000);
    // Host loads bank B: pass instruction then halt
    ins0 = {8'h10, 24'($urandom)};
    apb(1, 8'h00, 32'h8); apb(1, 8'h0C, 0);
    nab_host_model_inst.xfer(0, ins0);
    chk(32'(seen_low), 32'h1);
    nab_host_model_inst.xfer(0, 32'h0);
    apb(0, 8'h0C, 0); chk(r, 32'h2);
    // Swap banks, start the control unit
    apb(1, 8'h00, 32'hA); apb(0, 8'h00, 0); chk(32'(r[13]), 32'h1);
    apb(1, 8'h04, 0); apb(1, 8'h00, 32'hB);
    next_instr(w);
    chk48(w, {16'h0, ins0});
    do apb(0, 8'h00, 0); while (r[10] !== 1'b1);
    chk(32'(r[0]), 32'h0);
    apb(0, 8'h04, 0); chk(r, 32'h2);
    // Swap back; host reads the program word
    apb(1, 8'h00, 32'h8); apb(1, 8'h0C, 0);
    nab_host_model_inst.xfer(1, 32'h0);
    chk(hrd, ins0);
    // Create then collect from bank B; ids come from a model of the free stack
    nm = 8'($urandom);
    rl = 8'($urandom);
    ra = {8'h80, 8'($urandom)};
    cw = {8'h03, 16'h0000, 8'($urandom)};
    for (int i = 1; i <= 16; i++) begin
      fq.push_back(i);
    end
    apb(1, 8'h0C, 32'h2);
    nab_host_model_inst.xfer(0, {8'h01, nm, rl, nm ^ 8'h5A});
    nab_host_model_inst.xfer(0, cw);
    nab_host_model_inst.xfer(0, 32'h0);
    apb(1, 8'h08, {16'h0000, ra});
    apb(1, 8'h04, 32'h2);
    apb(1, 8'h00, 32'h40A);
    apb(1, 8'h00, 32'hB);
    ia = fq.pop_back();
    ib = fq.pop_back();
    next_instr(w);
    chk48(w, {8'h01, rl, 2'b00, 14'(ia), 2'b00, 14'(ib)});
    next_instr(w);
    chk48(w, {8'h01, rl | 8'h80, 2'b00, 14'(ib), 2'b00, 14'(ia)});
    next_instr(w);
    chk48(w, {16'h0000, cw});
    for (int j = 0; j < 4; j++) begin
      v[7:0] = 8'($urandom);
      exw = {exw[23:0], v[7:0]};
      ab <= v[7:0];
      adv <= 1'b1;
      repeat (3) @(posedge clock_i);
      adv <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
    adone <= 1'b1;
    repeat (4) @(posedge clock_i);
    adone <= 1'b0;
    do apb(0, 8'h00, 0); while (r[10] !== 1'b1);
    apb(0, 8'h04, 0);
    chk(r, 32'h5);
    apb(0, 8'h08, 0);
    chk(r, {16'h0000, ra + 16'h0001});
    apb(1, 8'h00, 32'h8);
    apb(1, 8'h0C, {16'h0000, ra});
    nab_host_model_inst.xfer(1, 32'h0);
    chk(hrd, exw);
    wrap_up();
  end
endmodule

// ---- sim/nab_host_model.sv ----
// Host side model: drives one word per strobe on the local bus
`timescale 1ns/10ps
module nab_host_model (
  input  wire logic        clock_i,
  output logic             owned_o,
  output logic             strobe_n_o,
  output logic             rw_n_o,
  output logic      [31:0] wdata_o
);
  initial begin
    owned_o    = 1'b0;
    strobe_n_o = 1'b1;
    rw_n_o     = 1'b1;
    wdata_o    = 32'h0;
  end

  // Own the bus, then a strobe held four cycles (latch = owned with strobe)
  task automatic xfer(input int rd, input logic [31:0] d);
    @(posedge clock_i);
    owned_o <= 1'b1;
    rw_n_o  <= 1'(rd);
    wdata_o <= d;
    @(posedge clock_i);
    strobe_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    strobe_n_o <= 1'b1;
    @(posedge clock_i);
    owned_o <= 1'b0;
    rw_n_o  <= 1'b1;
    wdata_o <= ~d; // Released data no longer shows the word
    repeat (4) @(posedge clock_i);
  endtask
endmodule
